/* File: pich_defines.svh */
// Timing counts and field constants for the interrupt controller host.
`ifndef PICH_DEFINES_SVH
`define PICH_DEFINES_SVH

// System clock rate in MHz; counts below derive from it.
`define PICH_CLK_MHZ      250
// Least time in ns rounded up to whole clock cycles.
`define PICH_CYC_UP(ns)   ((((ns) * `PICH_CLK_MHZ) + 999) / 1000)

// Bus timing in ns, as the device needs it.
`define PICH_SETUP_NS     50
`define PICH_RD_NS        420
`define PICH_WR_NS        400
`define PICH_RD_HOLD_NS   5
`define PICH_WR_HOLD_NS   40
`define PICH_FLOAT_NS     200

// Cycle counts derived from the times above.
`define PICH_SETUP_CYC    `PICH_CYC_UP(`PICH_SETUP_NS)
`define PICH_RD_CYC       `PICH_CYC_UP(`PICH_RD_NS)
`define PICH_WR_CYC       `PICH_CYC_UP(`PICH_WR_NS)
`define PICH_RD_HOLD_CYC  `PICH_CYC_UP(`PICH_RD_HOLD_NS)
`define PICH_WR_HOLD_CYC  `PICH_CYC_UP(`PICH_WR_HOLD_NS)
`define PICH_FLOAT_CYC    `PICH_CYC_UP(`PICH_FLOAT_NS)

// Register select values, the bit that marks the first init word, and the acknowledge pulse count.
`define PICH_RS_STATUS    1'b0
`define PICH_RS_MASK      1'b1
`define PICH_INIT1_BIT    4
`define PICH_ACK_PULSES   3

`endif

/* File: pich_pkg.sv */
// Types shared by the interrupt controller host.
package pich_pkg;

  // Kinds of order the host carries out.
  typedef enum logic [1:0] {
    PICH_OP_WRITE,
    PICH_OP_READ,
    PICH_OP_ACK,
    PICH_OP_INIT
  } pich_op_t;

  // One order from the user side.
  typedef struct packed {
    pich_op_t    op;
    logic        register_select;
    logic        cascade;
    logic [23:0] data;
  } pich_cmd_t;

  // Bus sequencer states.
  typedef enum logic [2:0] {
    PICH_ST_IDLE,
    PICH_ST_SETUP,
    PICH_ST_PULSE,
    PICH_ST_HOLD,
    PICH_ST_GAP
  } pich_state_t;

endpackage

/* File: pich_host.sv */
// Processor-side controller driving the priority interrupt controller pins.
`timescale 1ns/10ps
`include "pich_defines.svh"

// Overview of operation
// RULE_01: Device answers strobes only while selected. The host pulses acknowledge with select high, and the model answers it.
// RULE_02: Select 0 reads status, select 1 mask.
// RULE_03: Select-0 writes: bit 4 picks first word.
// RULE_04: Three acknowledge pulses fetch three call bytes.
// RULE_05: Request rising edge means new request.
// RULE_06: Each rising edge gives separate interrupt.
// RULE_07: Request must stay high through first ack.
// RULE_08: Highest ranked pending request wins.
// RULE_09: Master select high means master.
// RULE_10: Master drives slave identifier on chain lines. The project has no chain lines; the model only records the strap.
// RULE_11: Two init words single, three cascaded.
// RULE_12: One write strobe per init word.
// RULE_13: Operation words change behaviour, pick reads.
// RULE_14: Interrupt output high while request awaits.
// RULE_15: Level read back as binary number.
// RULE_16: Device drives data only when reading.
// RULE_17: Eight sources, sixty-four when cascaded.
// RULE_18: Select-1 writes steered by init sequencer.
// RULE_19: First init word clears mask and modes.
// RULE_20: Fixed nesting, input 0 highest.
// RULE_21: Service-done clears highest in-service bit.
// RULE_22: Pins synchronised, each edge acted once.
// RULE_23: Slave drives bytes on identifier match. The model drives the call bytes on every acknowledge pulse, whatever the strap.
module pich_host
  import pich_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // User orders and answers.
  input  wire logic        cmd_valid_i,
  input  wire pich_cmd_t   cmd_i,
  output logic             cmd_ready_o,
  output logic             rsp_valid_o,
  output logic [23:0]      rsp_data_o,
  output logic             irq_o,
  input  wire logic        cfg_master_i,
  // Device pins.
  output logic             chip_select_n_o,
  output logic             read_n_o,
  output logic             write_n_o,
  output logic             register_select_o,
  output logic             ack_strobe_n_o,
  output logic             master_select_pin_o,
  input  wire logic        interrupt_i,
  input  wire logic [7:0]  data_lines_i,
  output logic [7:0]       data_lines_o,
  output logic             data_lines_oe_o
);

  // Byte and select for one step of an order; the first init word always
  // carries its marker bit so the device cannot take it as an operation word.
  function automatic logic [8:0] step_fn(input pich_cmd_t c, input logic [1:0] idx);
    logic [8:0] r;
    r = {c.register_select, c.data[7:0]};
    if (c.op == PICH_OP_INIT) begin
      case (idx)
        2'd0:    r = {`PICH_RS_STATUS, c.data[7:0] | 8'(1 << `PICH_INIT1_BIT)}; // RULE_03
        2'd1:    r = {`PICH_RS_MASK, c.data[15:8]}; // RULE_12
        default: r = {`PICH_RS_MASK, c.data[23:16]}; // RULE_12
      endcase
    end
    return r;
  endfunction

  pich_state_t  state;
  pich_cmd_t    cmd;
  logic [1:0]   idx;
  logic [7:0]   cnt;
  logic [2:0]   irq_sync;
  logic [7:0]   data_s1;
  logic [7:0]   data_s2;
  logic [7:0]   data_s3;
  logic [7:0]   data_q;
  logic         irq_q;

  // Decoding of the order in hand.
  wire logic       is_ack     = (cmd.op == PICH_OP_ACK);
  wire logic       is_rd      = (cmd.op == PICH_OP_READ) || is_ack;
  wire logic [1:0] last_idx   = is_ack ? 2'(`PICH_ACK_PULSES - 1) :
                                (cmd.op == PICH_OP_INIT) ? (cmd.cascade ? 2'd2 : 2'd1) : // RULE_11
                                2'd0;
  wire logic       last_step  = (idx == last_idx);
  wire logic [7:0] pulse_lim  = is_rd ? 8'(`PICH_RD_CYC) : 8'(`PICH_WR_CYC);
  wire logic [7:0] hold_lim   = is_rd ? 8'(`PICH_RD_HOLD_CYC) : 8'(`PICH_WR_HOLD_CYC);
  wire logic [7:0] setup_lim  = 8'(`PICH_SETUP_CYC);
  wire logic [7:0] gap_lim    = 8'(`PICH_FLOAT_CYC);
  wire logic [1:0] next_idx   = (state == PICH_ST_IDLE) ? 2'd0 : idx + 2'd1;
  wire pich_cmd_t  next_cmd   = (state == PICH_ST_IDLE) ? cmd_i : cmd;
  wire logic [8:0] next_step  = step_fn(next_cmd, next_idx);
  wire logic       next_ack   = (next_cmd.op == PICH_OP_ACK);
  wire logic       next_wr    = (next_cmd.op == PICH_OP_WRITE) || (next_cmd.op == PICH_OP_INIT);
  wire logic       start      = (state == PICH_ST_IDLE) && cmd_valid_i && cmd_ready_o;
  wire logic       cnt_done   =
    (state == PICH_ST_SETUP && cnt == setup_lim - 8'd1) ||
    (state == PICH_ST_PULSE && cnt == pulse_lim - 8'd1) ||
    (state == PICH_ST_HOLD  && cnt == hold_lim - 8'd1)  ||
    (state == PICH_ST_GAP   && cnt == gap_lim - 8'd1);

  // Three-stage synchronisers; a new value counts once stages two and three
  // agree, so a bus caught mid-change never leaks a mixed byte.
  always_ff @(posedge clk_sys_i) begin
    irq_sync <= {irq_sync[1:0], interrupt_i};
    data_s1  <= data_lines_i;
    data_s2  <= data_s1;
    data_s3  <= data_s2;
    if (srst_i) begin
      irq_q  <= 1'b0;
      data_q <= 8'h00;
    end else begin
      if (irq_sync[1] == irq_sync[2]) irq_q <= irq_sync[2]; // RULE_22
      if (data_s2 == data_s3) data_q <= data_s3; // RULE_22
    end
  end

  // Interrupt level toward the user and the role strap toward the device.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_o               <= 1'b0;
      master_select_pin_o <= 1'b0;
    end else begin
      irq_o               <= irq_q;
      master_select_pin_o <= cfg_master_i;
    end
  end

  // Step counter shared by all phases of a bus cycle.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || start || cnt_done) cnt <= 8'h00;
    else if (state != PICH_ST_IDLE) cnt <= cnt + 8'd1;
  end

  // Bus sequencer: setup, strobe, hold and float gap for every step. The
  // gap after each step lets the device release the data lines before the
  // host may drive them again.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state             <= PICH_ST_IDLE;
      cmd               <= '0;
      idx               <= 2'd0;
      cmd_ready_o       <= 1'b0;
      rsp_valid_o       <= 1'b0;
      rsp_data_o        <= 24'h000000;
      chip_select_n_o   <= 1'b1;
      read_n_o          <= 1'b1;
      write_n_o         <= 1'b1;
      ack_strobe_n_o    <= 1'b1;
      register_select_o <= 1'b0;
      data_lines_o      <= 8'h00;
      data_lines_oe_o   <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      case (state)
        PICH_ST_IDLE: begin
          cmd_ready_o <= 1'b1;
          if (start) begin
            cmd         <= cmd_i;
            cmd_ready_o <= 1'b0;
            rsp_data_o  <= 24'h000000;
          end
        end
        PICH_ST_PULSE: begin
          if (cnt_done) begin
            read_n_o       <= 1'b1;
            write_n_o      <= 1'b1;
            ack_strobe_n_o <= 1'b1;
            if (is_rd) rsp_data_o[8*idx +: 8] <= data_q; // RULE_04
          end
        end
        PICH_ST_HOLD: begin
          if (cnt_done) begin
            chip_select_n_o <= 1'b1;
            data_lines_oe_o <= 1'b0;
            state           <= PICH_ST_GAP;
          end
        end
        PICH_ST_GAP: begin
          if (cnt_done && last_step) begin
            rsp_valid_o <= 1'b1;
            cmd_ready_o <= 1'b1;
            state       <= PICH_ST_IDLE;
          end
        end
        PICH_ST_SETUP: begin
          if (cnt_done) begin
            read_n_o       <= !(is_rd && !is_ack);
            write_n_o      <= is_rd; // RULE_12
            ack_strobe_n_o <= !is_ack; // RULE_04
            state          <= PICH_ST_PULSE;
          end
        end
        default: state <= PICH_ST_IDLE;
      endcase
      // Entry into setup, shared by a fresh order and a following step.
      if (start || (state == PICH_ST_GAP && cnt_done && !last_step)) begin
        idx               <= next_idx;
        chip_select_n_o   <= next_ack;
        register_select_o <= next_step[8];
        data_lines_o      <= next_step[7:0];
        data_lines_oe_o   <= next_wr;
        state             <= PICH_ST_SETUP;
      end
      if (state == PICH_ST_PULSE && cnt_done) state <= PICH_ST_HOLD;
    end
  end

  // Helper counts of strobe pulses within one order and of write strobe low cycles, read only by checks.
  logic [2:0] wr_pulses;
  logic [2:0] ack_pulses;
  logic [7:0] wr_low;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || start) begin
      wr_pulses  <= 3'd0;
      ack_pulses <= 3'd0;
    end else begin
      if (state == PICH_ST_SETUP && cnt_done && !is_rd) wr_pulses <= wr_pulses + 3'd1;
      if (state == PICH_ST_SETUP && cnt_done && is_ack) ack_pulses <= ack_pulses + 3'd1;
    end
    if (srst_i || write_n_o) wr_low <= 8'h00;
    else wr_low <= wr_low + 8'd1;
  end

  // End of a write strobe pulse: it rises, then is still high the next cycle.
  sequence s_wr_release;
    $rose(write_n_o) ##1 write_n_o;
  endsequence

  property p_init_bit4;
    @(posedge clk_sys_i) disable iff (srst_i)
      ($fell(write_n_o) && cmd.op == PICH_OP_INIT && idx == 2'd0)
        |-> data_lines_o[`PICH_INIT1_BIT] && register_select_o == `PICH_RS_STATUS;
  endproperty
  a_init_bit4: assert property (p_init_bit4) else $error("init word 1 lacks bit 4"); // RULE_03

  property p_ack_three;
    @(posedge clk_sys_i) disable iff (srst_i)
      (rsp_valid_o && is_ack) |-> ack_pulses == 3'(`PICH_ACK_PULSES);
  endproperty
  a_ack_three: assert property (p_ack_three) else $error("ack order without three pulses"); // RULE_04

  property p_ack_no_select;
    @(posedge clk_sys_i) disable iff (srst_i)
      !ack_strobe_n_o |-> chip_select_n_o && !data_lines_oe_o && read_n_o;
  endproperty
  a_ack_no_select: assert property (p_ack_no_select) else $error("ack pulse overlaps bus cycle"); // RULE_04

  property p_init_count;
    @(posedge clk_sys_i) disable iff (srst_i)
      (rsp_valid_o && cmd.op == PICH_OP_INIT) |-> wr_pulses == (cmd.cascade ? 3'd3 : 3'd2);
  endproperty
  a_init_count: assert property (p_init_count) else $error("wrong init word count"); // RULE_11

  property p_wr_width;
    @(posedge clk_sys_i) disable iff (srst_i)
      $rose(write_n_o) |-> $past(wr_low) >= 8'(`PICH_WR_CYC - 1);
  endproperty
  a_wr_width: assert property (p_wr_width) else $error("write strobe too short"); // RULE_12

  property p_wr_data_hold;
    @(posedge clk_sys_i) disable iff (srst_i)
      s_wr_release |-> data_lines_oe_o && !chip_select_n_o && $stable(data_lines_o);
  endproperty
  a_wr_data_hold: assert property (p_wr_data_hold) else $error("data dropped after write"); // RULE_12

  property p_strobe_selected;
    @(posedge clk_sys_i) disable iff (srst_i)
      (!read_n_o || !write_n_o) |-> !chip_select_n_o && ack_strobe_n_o;
  endproperty
  a_strobe_selected: assert property (p_strobe_selected) else $error("strobe without select"); // RULE_12

  property p_one_strobe;
    @(posedge clk_sys_i) disable iff (srst_i)
      $fell(write_n_o) |-> !write_n_o [*8];
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("write strobe glitch"); // RULE_12

endmodule

/* File: pich_dev_model.sv */
// Behavioural model of the interrupt controller device that the host drives.
`timescale 1ns/10ps
module pich_dev_model #(
  parameter int         RD_DLY_NS = 0,
  parameter logic [7:0] CALL_OP   = 8'hCD
) (
  // Bus pins from the host.
  input  wire logic       chip_select_n_i,
  input  wire logic       read_n_i,
  input  wire logic       write_n_i,
  input  wire logic       register_select_i,
  input  wire logic       ack_strobe_n_i,
  input  wire logic       master_select_pin_i,
  input  wire logic [7:0] data_lines_i,
  // Request inputs from the sources.
  input  wire logic [7:0] request_lines_i,
  // Answers toward the host.
  output logic            interrupt_o,
  output logic [7:0]      data_lines_o,
  output logic            data_lines_oe_o
);
  logic [7:0] pending_requests = 8'h00, in_service_bits = 8'h00, request_mask = 8'h00;
  logic [7:0] word1 = 8'h00, word2 = 8'h00, prev_lines = 8'h00, ack_byte = 8'h00;
  logic [2:0] lvl = 3'h0;
  logic [1:0] init_step = 2'h0, ack_count = 2'h0;
  logic       read_in_service = 1'b0, is_master = 1'b0;
  int         top;

  // Lowest set index wins; 8 means nothing is set.
  function automatic int best(input logic [7:0] v);
    for (int i = 0; i < 8; i++) if (v[i]) return i;
    return 8;
  endfunction

  // A level in service blocks itself and every level below it.
  assign top = best(pending_requests & ~request_mask);
  assign interrupt_o = (top < 8) && (best(in_service_bits) > top);

  // Rising lines latch a request; a line that falls early withdraws it.
  always @(request_lines_i) begin
    pending_requests = (pending_requests | (request_lines_i & ~prev_lines)) & request_lines_i;
    prev_lines = request_lines_i;
  end

  // The strap is only recorded; cascade lines are not modelled.
  always @(master_select_pin_i) is_master = master_select_pin_i;

  // Writes land on the trailing strobe edge and only while selected.
  always @(posedge write_n_i) begin
    if (!chip_select_n_i) begin
      if (!register_select_i && data_lines_i[4]) begin
        word1 = data_lines_i;
        request_mask = 8'h00;
        read_in_service = 1'b0;
        init_step = 2'h1;
        prev_lines = request_lines_i;
      end else if (register_select_i && init_step == 2'h1) begin
        word2 = data_lines_i;
        init_step = word1[1] ? 2'h0 : 2'h2;
      end else if (register_select_i && init_step == 2'h2) begin
        init_step = 2'h0;
      end else if (register_select_i) begin
        request_mask = data_lines_i;
      end else if (!data_lines_i[3] && data_lines_i[5] && in_service_bits != 8'h00) begin
        in_service_bits[best(in_service_bits)] = 1'b0;
      end else if (data_lines_i[3] && data_lines_i[1]) begin
        read_in_service = data_lines_i[0];
      end
    end
  end

  // Only the four-byte call interval is modelled, so the level lands at bit 2.
  always @(negedge ack_strobe_n_i) begin
    if (ack_count == 2'h0) begin
      ack_byte = CALL_OP;
      if (top < 8) begin
        lvl = top[2:0];
        in_service_bits[lvl] = 1'b1;
        pending_requests[lvl] = 1'b0;
      end
    end else if (ack_count == 2'h1) begin
      ack_byte = (word1 & 8'hE0) | {3'h0, lvl, 2'h0};
    end else begin
      ack_byte = word2;
    end
    ack_count = (ack_count == 2'h2) ? 2'h0 : ack_count + 2'h1;
  end

  // The delay stands for slow data valid and slow float, both within the limits.
  assign #(RD_DLY_NS) data_lines_oe_o = (!chip_select_n_i && !read_n_i) || !ack_strobe_n_i;
  assign data_lines_o = !ack_strobe_n_i ? ack_byte : register_select_i ? request_mask :
                        read_in_service ? in_service_bits : pending_requests;
endmodule

/* File: pich_host_bench.sv */
// Self-checking bench for the interrupt controller host against the device model.
`timescale 1ns/10ps
module pich_host_bench;
  import pich_pkg::*;
  localparam logic [7:0] CALL_OP = 8'hCD;
  logic        clk_sys_i = 1'b0, srst_i = 1'b1, cmd_valid_i = 1'b0, cfg_master_i = 1'b0;
  pich_cmd_t   cmd_i = '0;
  logic        cmd_ready_o, rsp_valid_o, irq_o, chip_select_n_o, read_n_o, write_n_o;
  logic        register_select_o, ack_strobe_n_o, master_select_pin_o, data_lines_oe_o;
  logic        interrupt_i, dev_oe;
  logic [23:0] rsp_data_o;
  logic [7:0]  data_lines_o, dev_data, bus, request_lines = 8'h00, last_dev = 8'h00, mask_val;
  logic [23:0] expected[$];
  int          num_errors = 0, samples_checked = 0, seed = 42739;

  pich_host uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .irq_o(irq_o), .cfg_master_i(cfg_master_i),
    .chip_select_n_o(chip_select_n_o), .read_n_o(read_n_o), .write_n_o(write_n_o),
    .register_select_o(register_select_o), .ack_strobe_n_o(ack_strobe_n_o),
    .master_select_pin_o(master_select_pin_o), .interrupt_i(interrupt_i),
    .data_lines_i(bus), .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o));
  pich_dev_model #(.RD_DLY_NS(150), .CALL_OP(CALL_OP)) dev (.chip_select_n_i(chip_select_n_o),
    .read_n_i(read_n_o), .write_n_i(write_n_o), .register_select_i(register_select_o),
    .ack_strobe_n_i(ack_strobe_n_o), .master_select_pin_i(master_select_pin_o),
    .data_lines_i(bus), .request_lines_i(request_lines), .interrupt_o(interrupt_i),
    .data_lines_o(dev_data), .data_lines_oe_o(dev_oe));

  // A released bus shows the inverse of the last byte the device drove, so stale data cannot pass.
  always @(dev_data or dev_oe) if (dev_oe) last_dev = dev_data;
  assign bus = data_lines_oe_o ? data_lines_o : dev_oe ? dev_data : ~last_dev;

  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Bounded wait for the host to be idle; checking on the falling edge avoids races.
  task automatic wait_ready();
    int n;
    for (n = 0; n < 2000; n++) begin
      @(negedge clk_sys_i);
      if (cmd_ready_o === 1'b1) break;
    end
    if (n == 2000) begin
      num_errors++;
      give_verdict();
    end
  endtask

  // Offer one order, note its answer, and wait until the host is idle again.
  task automatic order(input pich_op_t op, input logic rs, input logic cas,
                       input logic [23:0] d, input logic [23:0] exp);
    wait_ready();
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= '{op: op, register_select: rs, cascade: cas, data: d};
    expected.push_back(exp);
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
    wait_ready();
  endtask

  // The synchronised interrupt is given a short bounded time to settle.
  task automatic wait_irq(input logic exp);
    for (int n = 0; n < 32 && irq_o !== exp; n++) @(negedge clk_sys_i);
    check({23'h0, irq_o}, {23'h0, exp});
  endtask

  // Every finished order is matched against the oldest note.
  always @(posedge clk_sys_i) begin
    if (rsp_valid_o === 1'b1) begin
      if (expected.size() == 0) begin
        num_errors++;
        $display("mismatch at %0t: seen %h expected none", $time, rsp_data_o);
      end else check(rsp_data_o, expected.pop_front());
    end
  end

  initial begin
    repeat (6) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    cfg_master_i <= 1'b1;
    mask_val = 8'($random(seed));
    order(PICH_OP_INIT, 1'b0, 1'b0, 24'h004016, 24'h0);
    order(PICH_OP_WRITE, 1'b1, 1'b0, {16'h0, mask_val}, 24'h0);
    order(PICH_OP_READ, 1'b1, 1'b0, 24'h0, {16'h0, mask_val});
    check({23'h0, master_select_pin_o}, 24'h1);
    @(posedge clk_sys_i);
    cfg_master_i <= 1'b0;
    // Marker bit left clear here so the host must set it on its own.
    order(PICH_OP_INIT, 1'b0, 1'b1, 24'h034004, 24'h0);
    order(PICH_OP_READ, 1'b1, 1'b0, 24'h0, 24'h0);
    order(PICH_OP_WRITE, 1'b1, 1'b0, 24'h000081, 24'h0);
    order(PICH_OP_READ, 1'b1, 1'b0, 24'h0, 24'h000081);
    check({23'h0, master_select_pin_o}, 24'h0);
    order(PICH_OP_WRITE, 1'b1, 1'b0, 24'h0, 24'h0);
    order(PICH_OP_WRITE, 1'b0, 1'b0, 24'h00000A, 24'h0);
    request_lines <= 8'h24;
    order(PICH_OP_READ, 1'b0, 1'b0, 24'h0, 24'h000024);
    wait_irq(1'b1);
    order(PICH_OP_ACK, 1'b0, 1'b0, 24'h0, {8'h40, 8'h08, CALL_OP});
    wait_irq(1'b0);
    order(PICH_OP_WRITE, 1'b0, 1'b0, 24'h00000B, 24'h0);
    order(PICH_OP_READ, 1'b0, 1'b0, 24'h0, 24'h000004);
    order(PICH_OP_WRITE, 1'b0, 1'b0, 24'h000020, 24'h0);
    wait_irq(1'b1);
    order(PICH_OP_ACK, 1'b0, 1'b0, 24'h0, {8'h40, 8'h14, CALL_OP});
    order(PICH_OP_WRITE, 1'b0, 1'b0, 24'h000020, 24'h0);
    order(PICH_OP_READ, 1'b0, 1'b0, 24'h0, 24'h0);
    request_lines <= 8'h2C;
    wait_irq(1'b1);
    request_lines <= 8'h24;
    wait_irq(1'b0);
    check(24'(expected.size()), 24'h0);
    give_verdict();
  end
endmodule
